// *** src/eewp_cmdrom.sv ***
// command prefix lookup for set and clear protection sequences
`timescale 1ns/1ps
`include "eewp_defines.svh"
module eewp_cmdrom
  import eewp_pkg::*;
#(
  parameter logic [14:0] CMD_A0 = `EEWP_CMD_A0,
  parameter logic [14:0] CMD_A1 = `EEWP_CMD_A1,
  parameter logic [7:0]  SET_D0 = `EEWP_SET_D0,
  parameter logic [7:0]  SET_D1 = `EEWP_SET_D1,
  parameter logic [7:0]  SET_D2 = `EEWP_SET_D2,
  parameter logic [7:0]  CLR_D2 = `EEWP_CLR_D2,
  parameter logic [7:0]  CLR_D5 = `EEWP_CLR_D5
) (
  // select
  input  wire logic       clr,
  input  wire logic [2:0] idx,
  // command word
  output eewp_word_t      word
);
  always_comb begin
    word = '{addr: CMD_A0, data: SET_D0};
    case (idx)
      3'h0: word = '{addr: CMD_A0, data: SET_D0};
      3'h1: word = '{addr: CMD_A1, data: SET_D1};
      3'h2: word = '{addr: CMD_A0, data: clr ? CLR_D2 : SET_D2};
      3'h3: word = '{addr: CMD_A0, data: SET_D0};
      3'h4: word = '{addr: CMD_A1, data: SET_D1};
      3'h5: word = '{addr: CMD_A0, data: CLR_D5};
      default: word = '{addr: CMD_A0, data: SET_D0};
    endcase
  end
endmodule // eewp_cmdrom

// *** src/eewp_defines.svh ***
// constants for the parallel eeprom write/protect host controller
`ifndef EEWP_DEFINES_SVH
`define EEWP_DEFINES_SVH
`define EEWP_CLK_NS          50
`define EEWP_STROBE_NS       150
`define EEWP_STROBE_CYC      ((`EEWP_STROBE_NS + `EEWP_CLK_NS - 1) / `EEWP_CLK_NS)
`define EEWP_BLC_US          100
`define EEWP_BLC_CYC         ((`EEWP_BLC_US * 1000) / `EEWP_CLK_NS)
`define EEWP_GAP_CYC         ((`EEWP_BLC_CYC * 3) / 4)
`define EEWP_WC_MS           10
`define EEWP_WC_CYC          ((`EEWP_WC_MS * 1000000) / `EEWP_CLK_NS)
`define EEWP_POLL_LIMIT      32'd400000
`define EEWP_PAGE_BYTES      128
`define EEWP_BIT_COMP        7
`define EEWP_BIT_TOGG        6
`define EEWP_CMD_A0          15'h5555
`define EEWP_CMD_A1          15'h2aaa
`define EEWP_SET_D0          8'haa
`define EEWP_SET_D1          8'h55
`define EEWP_SET_D2          8'ha0
`define EEWP_CLR_D2          8'h80
`define EEWP_CLR_D5          8'h20
`endif

// *** src/eewp_host.sv ***
// host controller: page writes with protection prefix, reads, status polling
//
// How it works
// - host never trusts the first or last bit 6 level alone
// - with PROT set every page gets the command prefix
// - prefix is three command writes to fixed addresses in order
// - clear op sends six command writes then waits one write cycle
// - command writes go back to back with no other access between
// - ce is driven per device; oe and we may be shared
// - next byte strobe starts well inside 100 us of the last
// - page select address taken from the first byte of the page
`timescale 1ns/1ps
`include "eewp_defines.svh"
module eewp_host
  import eewp_pkg::*;
#(
  parameter int          WC_CYC    = `EEWP_WC_CYC,
  parameter logic [14:0] CMD_A0    = `EEWP_CMD_A0,
  parameter logic [14:0] CMD_A1    = `EEWP_CMD_A1
) (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  // user request
  input  wire logic        REQ,
  input  wire eewp_op_t    OP,
  input  wire logic        PROT,
  input  wire eewp_word_t  REQ_WORD,
  input  wire logic [7:0]  LEN,
  // user byte stream for a page, status and read data
  input  wire logic [7:0]  WDATA,
  output logic             WDATA_TAKE,
  output logic             BUSY,
  output logic             DONE,
  output logic             TIMEOUT,
  output logic [7:0]       RDATA,
  // device pins
  output eewp_word_t       MEM_WORD,
  output eewp_strb_t       MEM_STRB,
  output logic             MEM_DQ_OE,
  input  wire logic [7:0]  MEM_DQ_IN
);
  localparam int STB  = `EEWP_STROBE_CYC;

  eewp_state_t state_reg;
  eewp_state_t state_next;
  eewp_op_t    op_reg;
  logic        prot_reg;
  logic [2:0]  cmd_idx_reg;
  logic [2:0]  cmd_cnt_reg;
  logic [7:0]  left_reg;
  logic [14:0] page_addr_reg;
  logic [7:0]  last_data_reg;
  logic        in_cmd_reg;
  logic        first_poll_reg;
  logic        prev_tog_reg;
  logic [7:0]  poll_q_reg;
  logic [31:0] tmr_reg;
  logic [31:0] poll_cnt_reg;
  eewp_word_t  cmd_word;

  eewp_cmdrom #(
    .CMD_A0 (CMD_A0),
    .CMD_A1 (CMD_A1)
  ) u_cmdrom (
    .clr  (op_reg == EEWP_OP_CLR),
    .idx  (cmd_idx_reg),
    .word (cmd_word)
  );

  wire tmr_done = (tmr_reg == 32'd0);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      EEWP_IDLE: if (REQ) state_next = EEWP_PREP;
      EEWP_PREP: state_next = (op_reg == EEWP_OP_READ) ? EEWP_RSTB
                                                       : EEWP_WSTB;
      EEWP_WSTB: if (tmr_done) state_next = EEWP_WGAP;
      EEWP_WGAP: begin
        if (tmr_done) begin
          if (in_cmd_reg && cmd_idx_reg != cmd_cnt_reg)
            state_next = EEWP_WSTB;
          else if (!in_cmd_reg && left_reg != 8'd0)
            state_next = EEWP_WSTB;
          else if (op_reg == EEWP_OP_CLR)
            state_next = EEWP_WAIT;
          else if (in_cmd_reg)
            state_next = EEWP_WSTB;
          else
            state_next = EEWP_POLL;
        end
      end
      EEWP_RSTB: if (tmr_done) state_next = EEWP_RGAP;
      EEWP_RGAP: state_next = EEWP_DONE;
      EEWP_POLL: state_next = EEWP_PSTB;
      EEWP_PSTB: if (tmr_done) state_next = EEWP_PGAP;
      EEWP_PGAP: begin
        if (poll_cnt_reg == `EEWP_POLL_LIMIT)
          state_next = EEWP_DONE;
        else if (!first_poll_reg
                 && poll_q_reg[`EEWP_BIT_TOGG] == prev_tog_reg
                 && poll_q_reg[`EEWP_BIT_COMP]
                    == last_data_reg[`EEWP_BIT_COMP])
          state_next = EEWP_DONE;
        else
          state_next = EEWP_PSTB;
      end
      EEWP_WAIT: if (tmr_done) state_next = EEWP_DONE;
      EEWP_DONE: state_next = EEWP_IDLE;
      default:   state_next = EEWP_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) state_reg <= EEWP_IDLE;
    else       state_reg <= state_next;
  end

  // strobe / gap timer
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tmr_reg <= 32'd0;
    end else if (state_next != state_reg) begin
      case (state_next)
        EEWP_WSTB, EEWP_RSTB, EEWP_PSTB: tmr_reg <= 32'(STB - 1);
        EEWP_WGAP: tmr_reg <= 32'(STB - 1);
        EEWP_WAIT: tmr_reg <= 32'(WC_CYC - 1);
        default:   tmr_reg <= 32'd0;
      endcase
    end else if (!tmr_done) begin
      tmr_reg <= tmr_reg - 32'd1;
    end
  end

  // request capture and sequencing
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      op_reg        <= EEWP_OP_READ;
      prot_reg      <= 1'b0;
      cmd_idx_reg   <= 3'd0;
      cmd_cnt_reg   <= 3'd0;
      left_reg      <= 8'd0;
      page_addr_reg <= 15'h0000;
      in_cmd_reg    <= 1'b0;
    end else if (state_reg == EEWP_IDLE && REQ) begin
      op_reg        <= OP;
      prot_reg      <= PROT;
      cmd_idx_reg   <= 3'd0;
      cmd_cnt_reg   <= (OP == EEWP_OP_CLR) ? 3'd6 : 3'd3;
      left_reg      <= (LEN > 8'(`EEWP_PAGE_BYTES)) ?
                       8'(`EEWP_PAGE_BYTES) : LEN;
      page_addr_reg <= REQ_WORD.addr;
      in_cmd_reg    <= (OP == EEWP_OP_CLR)
                       || (OP == EEWP_OP_WRITE && PROT);
    end else if (state_reg == EEWP_WGAP && state_next == EEWP_WSTB) begin
      if (in_cmd_reg && cmd_idx_reg == cmd_cnt_reg)
        in_cmd_reg <= 1'b0;
    end else if (state_reg == EEWP_WSTB && state_next == EEWP_WGAP) begin
      if (in_cmd_reg) cmd_idx_reg <= cmd_idx_reg + 3'd1;
      else if (left_reg != 8'd0) begin
        // step only after the byte left the pins, so the next one moves on
        left_reg           <= left_reg - 8'd1;
        page_addr_reg[6:0] <= page_addr_reg[6:0] + 7'd1;
      end
    end
  end

  // pin drive: addr/data held over the strobe, bus released one cycle after it
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      MEM_WORD   <= '0;
      MEM_STRB   <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      MEM_DQ_OE  <= 1'b0;
      WDATA_TAKE <= 1'b0;
    end else begin
      WDATA_TAKE <= 1'b0;
      case (state_next)
        EEWP_WSTB: begin
          if (state_reg != EEWP_WSTB) begin
            if (in_cmd_reg && !(state_reg == EEWP_WGAP
                && cmd_idx_reg == cmd_cnt_reg))
              MEM_WORD <= cmd_word;
            else begin
              MEM_WORD <= '{addr: page_addr_reg, data: WDATA};
              WDATA_TAKE <= 1'b1;
            end
          end
          MEM_STRB  <= '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
          MEM_DQ_OE <= 1'b1;
        end
        EEWP_RSTB, EEWP_PSTB: begin
          if (state_next == EEWP_RSTB) MEM_WORD.addr <= page_addr_reg;
          MEM_STRB  <= '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
          MEM_DQ_OE <= 1'b0;
        end
        default: begin
          MEM_STRB  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
          // data held one cycle past the we rising edge for hold time
          MEM_DQ_OE <= (state_reg == EEWP_WSTB);
        end
      endcase
    end
  end

  // poll bookkeeping
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      last_data_reg  <= 8'h00;
      first_poll_reg <= 1'b1;
      prev_tog_reg   <= 1'b0;
      poll_cnt_reg   <= 32'd0;
      poll_q_reg     <= 8'h00;
    end else begin
      if (WDATA_TAKE) last_data_reg <= MEM_WORD.data;
      // sample while ce and oe are still low; the bus floats in the gap
      if (state_reg == EEWP_PSTB && tmr_done) poll_q_reg <= MEM_DQ_IN;
      if (state_reg == EEWP_POLL) begin
        first_poll_reg <= 1'b1;
        poll_cnt_reg   <= 32'd0;
      end else if (state_reg == EEWP_PGAP) begin
        first_poll_reg <= 1'b0;
        prev_tog_reg   <= poll_q_reg[`EEWP_BIT_TOGG];
        poll_cnt_reg   <= poll_cnt_reg + 32'd1;
      end
    end
  end

  // user status
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      BUSY    <= 1'b0;
      DONE    <= 1'b0;
      TIMEOUT <= 1'b0;
      RDATA   <= 8'h00;
    end else begin
      BUSY <= (state_next != EEWP_IDLE);
      DONE <= (state_next == EEWP_DONE);
      if (state_reg == EEWP_IDLE && REQ) TIMEOUT <= 1'b0;
      if (state_reg == EEWP_PGAP && poll_cnt_reg == `EEWP_POLL_LIMIT)
        TIMEOUT <= 1'b1;
      if (state_reg == EEWP_RSTB && tmr_done) RDATA <= MEM_DQ_IN;
    end
  end

  bus_free_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (MEM_STRB.oe_n == 1'b0) |-> !MEM_DQ_OE)
    else $error("host drives bus during read");
  write_inhibit_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (MEM_STRB.we_n == 1'b0) |-> (MEM_STRB.oe_n && !MEM_STRB.ce_n))
    else $error("write strobe with oe low or ce high");
  stable_word_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (!MEM_STRB.we_n && $past(!MEM_STRB.we_n)) |-> $stable(MEM_WORD))
    else $error("address or data moved during strobe");
  page_len_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    left_reg <= 8'(`EEWP_PAGE_BYTES))
    else $error("page longer than 128 bytes");
  cmd_count_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (state_reg == EEWP_WAIT) |-> (cmd_idx_reg == 3'd6))
    else $error("clear wait before six commands");
  byte_gap_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    $rose(MEM_STRB.we_n) |-> ##[1:40] (!MEM_STRB.we_n
      || state_reg inside {EEWP_POLL, EEWP_PSTB, EEWP_WAIT, EEWP_DONE,
                           EEWP_IDLE}))
    else $error("byte load gap too long");
  read_strobe_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (state_reg == EEWP_RSTB) |-> (!MEM_STRB.ce_n && !MEM_STRB.oe_n))
    else $error("read without ce and oe low");
  poll_done_a: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
    (state_reg == EEWP_PGAP && state_next == EEWP_DONE && !TIMEOUT
      && poll_cnt_reg != `EEWP_POLL_LIMIT)
    |-> (poll_q_reg[`EEWP_BIT_TOGG] == prev_tog_reg))
    else $error("poll ended while bit 6 toggling");
endmodule // eewp_host

// *** src/eewp_pkg.sv ***
// types for the parallel eeprom write/protect host controller
package eewp_pkg;
  typedef enum logic [3:0] {
    EEWP_IDLE  = 4'b0000,
    EEWP_PREP  = 4'b0001,
    EEWP_WSTB  = 4'b0010,
    EEWP_WGAP  = 4'b0011,
    EEWP_RSTB  = 4'b0100,
    EEWP_RGAP  = 4'b0101,
    EEWP_POLL  = 4'b0110,
    EEWP_PSTB  = 4'b0111,
    EEWP_PGAP  = 4'b1000,
    EEWP_WAIT  = 4'b1001,
    EEWP_DONE  = 4'b1010
  } eewp_state_t;
  typedef enum logic [1:0] {
    EEWP_OP_READ  = 2'b00,
    EEWP_OP_WRITE = 2'b01,
    EEWP_OP_CLR   = 2'b10
  } eewp_op_t;
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0]  data;
  } eewp_word_t;
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
  } eewp_strb_t;
endpackage

// *** tb/eewp_dev_model.sv ***
// behavioural parallel eeprom with status bits and write protection
`timescale 1ns/1ps
`include "eewp_defines.svh"
module eewp_dev_model
  import eewp_pkg::*;
#(
  parameter int         BLC_NS = 100000,
  parameter int         WC_NS  = 2500,
  parameter eewp_word_t S0 = {`EEWP_CMD_A0, `EEWP_SET_D0},
  parameter eewp_word_t S1 = {`EEWP_CMD_A1, `EEWP_SET_D1},
  parameter eewp_word_t S2 = {`EEWP_CMD_A0, `EEWP_SET_D2},
  parameter eewp_word_t C2 = {`EEWP_CMD_A0, `EEWP_CLR_D2},
  parameter eewp_word_t C5 = {`EEWP_CMD_A0, `EEWP_CLR_D5}
) (
  // pins from the host
  input  eewp_word_t w,
  input  eewp_strb_t s,
  input  logic [7:0] din,
  // read drive
  output logic       oe,
  output logic [7:0] q
);
  logic [7:0]   mem [32768];
  logic [137:0] hist = '0;
  eewp_word_t   pg [$];
  eewp_word_t   cur;
  eewp_word_t   last = '0;
  logic         sdp = 1'b0;
  logic         open_w = 1'b0;
  logic         clr = 1'b0;
  logic         ld = 1'b0;
  logic         prog = 1'b0;
  logic         tog;
  time          t_we;
  event         go;
  wire          busy = ld | prog;
  wire          wr = !s.ce_n && !s.we_n && s.oe_n;
  assign oe = !s.ce_n && !s.oe_n;
  assign q = busy ? {~last.data[7], tog, last.data[5:0]} : mem[w.addr];
  initial begin
    foreach (mem[i]) mem[i] = 8'hff;
    tog = 1'($urandom);
  end
  always @(posedge oe) if (busy) tog = ~tog;
  // address pins settle in the same step as the strobe; look just after
  always @(posedge wr) begin
    t_we = $time;
    #1 cur.addr = w.addr;
  end
  always @(negedge wr) if (!prog && $time > 0) begin
    cur.data = din;
    hist = {hist[114:0], cur};
    if (hist[68:0] == {S0, S1, S2}) begin
      sdp = 1'b1;
      open_w = 1'b1;
    end else if (hist == {S0, S1, C2, S0, S1, C5}) begin
      clr = 1'b1;
      ->go;
    end else if (!(cur inside {S0, S1, C2}) && (!sdp || open_w)) begin
      pg.push_back(cur);
      last = cur;
      ->go;
    end
  end
  // page load window, then the internal programming cycle
  initial forever begin
    @(go);
    ld = 1'b1;
    while (!clr && $time - t_we < BLC_NS)
      #(BLC_NS - ($time - t_we));
    ld = 1'b0;
    prog = 1'b1;
    foreach (pg[i]) mem[pg[i].addr] = pg[i].data;
    pg.delete();
    open_w = 1'b0;
    #(WC_NS);
    if (clr) sdp = 1'b0;
    clr = 1'b0;
    prog = 1'b0;
  end
endmodule // eewp_dev_model

// *** tb/eewp_host_tb_top.sv ***
// self-checking bench: eeprom host controller against a device model
`timescale 1ns/1ps
module eewp_host_tb_top
  import eewp_pkg::*;
;
  logic        CORE_CLK = 1'b0, RSTN = 1'b0, REQ = 1'b0, PROT = 1'b0;
  eewp_op_t    OP = EEWP_OP_READ;
  eewp_word_t  REQ_WORD = '0, MEM_WORD;
  eewp_strb_t  MEM_STRB;
  logic [7:0]  LEN = 8'h01, WDATA = 8'h00, RDATA, dev_q, dq_bus;
  logic [7:0]  dq_last = 8'h00;
  logic        WDATA_TAKE, BUSY, DONE, TIMEOUT, MEM_DQ_OE, dev_oe;
  logic [7:0]  ref_mem [32768];
  logic [7:0]  pg [$];
  logic [14:0] a;
  bit          ref_sdp = 1'b0;
  int          err_total = 0, samples_checked = 0, cyc = 0;

  eewp_host #(.WC_CYC(60)) eewp_host_i (
    .CORE_CLK, .RSTN, .REQ, .OP, .PROT, .REQ_WORD, .LEN, .WDATA,
    .WDATA_TAKE, .BUSY, .DONE, .TIMEOUT, .RDATA, .MEM_WORD, .MEM_STRB,
    .MEM_DQ_OE, .MEM_DQ_IN(dq_bus)
  );
  eewp_dev_model eewp_dev_model_i (
    .w(MEM_WORD), .s(MEM_STRB), .din(dq_bus), .oe(dev_oe), .q(dev_q)
  );
  // a released bus shows the inverse of its last level
  assign dq_bus = MEM_DQ_OE ? MEM_WORD.data : dev_oe ? dev_q : ~dq_last;
  always @(posedge CORE_CLK) dq_last <= dq_bus;
  initial forever #25 CORE_CLK = ~CORE_CLK;

  task automatic cmp_byte(string nm, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_bit(string nm, logic e, logic g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      close_out();
    end
    if (RSTN && !MEM_STRB.we_n) cmp_bit("oe_n", 1'b1, MEM_STRB.oe_n);
    if (MEM_DQ_OE) cmp_bit("bus clash", 1'b0, dev_oe);
  end

  task automatic do_op(eewp_op_t op, logic p, logic [14:0] ad, int n);
    int k = 0;
    int t = 0;
    // a request is only taken in idle; wait out the previous operation
    while (BUSY === 1'b1) begin
      @(posedge CORE_CLK);
      #2;
    end
    OP = op;
    PROT = p;
    LEN = 8'(n);
    WDATA = pg.size() > 0 ? pg[0] : 8'h00;
    REQ_WORD = {ad, WDATA};
    REQ = 1'b1;
    @(posedge CORE_CLK);
    #2 REQ = 1'b0;
    while (DONE !== 1'b1 && t < 5000) begin
      if (WDATA_TAKE === 1'b1 && k + 1 < pg.size()) WDATA = pg[++k];
      @(posedge CORE_CLK);
      #2 t++;
    end
    cmp_bit("done", 1'b1, DONE);
  endtask
  task automatic rd_chk(logic [14:0] ad);
    pg.delete();
    do_op(EEWP_OP_READ, 1'b0, ad, 1);
    cmp_byte("rdata", ref_mem[ad], RDATA);
  endtask
  function automatic logic [14:0] pa(logic [14:0] ad, int i);
    return {ad[14:7], 7'(ad[6:0] + i)};
  endfunction
  task automatic fill(int n);
    pg.delete();
    repeat (n) pg.push_back(8'($urandom));
  endtask
  // a refused write keeps bit 7 so that polling still ends
  task automatic wr_page(logic p, logic [14:0] ad);
    int n = pg.size();
    if (ref_sdp && !p) foreach (pg[i]) pg[i][7] = ref_mem[pa(ad, i)][7];
    do_op(EEWP_OP_WRITE, p, ad, n);
    cmp_bit("timeout", 1'b0, TIMEOUT);
    if (p || !ref_sdp)
      foreach (pg[i]) ref_mem[pa(ad, i)] = pg[i];
    ref_sdp |= p;
    for (int i = 0; i < n; i++) rd_chk(pa(ad, i));
  endtask

  initial begin
    void'($urandom(99979));
    foreach (ref_mem[i]) ref_mem[i] = 8'hff;
    repeat (5) @(posedge CORE_CLK);
    #2 RSTN = 1'b1;
    cmp_bit("ce_n idle", 1'b1, MEM_STRB.ce_n);
    cmp_bit("dq_oe idle", 1'b0, MEM_DQ_OE);
    rd_chk(15'h0123);
    $display("test reset and blank read done");
    a = {8'($urandom), 7'h7d};
    fill(5);
    wr_page(1'b0, a);
    $display("test plain page done");
    a = {8'($urandom), 7'h00};
    fill(128);
    wr_page(1'b1, a);
    $display("test protected page done");
    RSTN = 1'b0;
    @(posedge CORE_CLK);
    #2 RSTN = 1'b1;
    pg = '{ref_mem[a] ^ 8'h7f};
    wr_page(1'b0, a);
    $display("test refused write done");
    pg.delete();
    do_op(EEWP_OP_CLR, 1'b0, 15'h0000, 1);
    ref_sdp = 1'b0;
    fill(3);
    wr_page(1'b0, a);
    $display("test clear done");
    repeat (4) begin
      fill(1 + $urandom % 4);
      wr_page(1'($urandom), 15'($urandom));
    end
    $display("test random pages done");
    close_out();
  end
endmodule // eewp_host_tb_top
